// ===== common/pwr_pkg.sv
// Purpose: Shared constants and types of the halt/idle power sequencer
// Assumes: 32-bit AXI4-Lite register bus, one register per aligned word
// Notes: All register fields sit in the low byte except the 16-bit TIMER value
package pwr_pkg;
    localparam logic [7:0] ADDR_PORTG = 8'h00;
    localparam logic [7:0] ADDR_INT_CTRL = 8'h04;
    localparam logic [7:0] ADDR_CAN_BUS = 8'h08;
    localparam logic [7:0] ADDR_M_WAKE_EN = 8'h0C;
    localparam logic [7:0] ADDR_LWKEN = 8'h10;
    localparam logic [7:0] ADDR_LWKPND = 8'h14;
    localparam logic [7:0] ADDR_MWKPND = 8'h18;
    localparam logic [7:0] ADDR_STATUS = 8'h1C;
    localparam logic [7:0] ADDR_TIMER = 8'h20;
    localparam int HALT_BIT = 7;
    localparam int IDLE_BIT = 6;
    localparam int TPEND_BIT = 5;
    localparam int TEN_BIT = 4;
    localparam int CAN_WAKE_BIT = 7;
    localparam int CAN_RX_EN_LO = 0;
    localparam int CAN_RX_EN_HI = 1;
    localparam logic [3:0] INSTR_DIV = 4'hA;
    localparam logic [3:0] DIV_LAST = 4'(INSTR_DIV - 4'h1);
    localparam int TMR_W = 16;
    localparam int TOGGLE_BIT = 12;
    localparam logic [15:0] STARTUP_LOAD = 16'h0100;
    localparam logic [15:0] TMR_RESET = 16'hFFFF;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef enum logic [1:0] {ST_RUN, ST_IDLE, ST_HALT, ST_STARTUP} pwr_state_t;
    typedef enum logic [3:0] {R_NONE, R_PORTG, R_INT_CTRL, R_CAN_BUS, R_M_WAKE_EN, R_LWKEN,
                              R_LWKPND, R_MWKPND, R_STATUS, R_TIMER} reg_sel_t;
    typedef struct packed {
        logic main_comp_en;
        logic wake_comp_en;
        logic vref_en;
        logic vref_oe_n;
    } can_ctrl_t;
endpackage : pwr_pkg

// ===== rtl/instr_clock_div.sv
// Purpose: Instruction tick from the oscillator clock
// Assumes: run is low while the oscillator is stopped or weak
// Notes: tick is a one-cycle pulse every ten running cycles
`timescale 1ns/10ps
module instr_clock_div (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // Control
    input wire logic run,
    output logic tick
);
    logic [3:0] cnt_q;
    logic [3:0] gap_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            cnt_q <= 4'h0;
            tick <= 1'b0;
        end else if (ce) begin
            tick <= 1'b0;
            if (run) begin
                if (cnt_q == pwr_pkg::DIV_LAST) begin
                    cnt_q <= 4'h0;
                    tick <= 1'b1;
                end else begin
                    cnt_q <= cnt_q + 4'h1;
                end
            end
        end
    end

    // Cycles since the last tick, saturating, so the spacing check needs no long repetition
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            gap_q <= 4'hF;
        end else if (ce) begin
            if (tick) begin
                gap_q <= 4'h0;
            end else if (gap_q != 4'hF) begin
                gap_q <= gap_q + 4'h1;
            end
        end
    end

    property p_div_spacing;
        @(posedge aclk) disable iff (!aresetn) tick |-> gap_q >= pwr_pkg::DIV_LAST;
    endproperty
    a_div_spacing: assert property (p_div_spacing) else $error("tick spacing under ten");
endmodule : instr_clock_div

// ===== rtl/idle_timer_ctr.sv
// Purpose: Free running down counter of instruction ticks
// Assumes: load has priority over counting
// Notes: toggle_q pulses for one cycle when a decrement changes bit twelve
`timescale 1ns/10ps
module idle_timer_ctr (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // Control
    input wire logic tick,
    input wire logic count_en,
    input wire logic load,
    input wire logic [15:0] load_val,
    // State
    output logic [15:0] value_q,
    output logic toggle_q
);
    logic [15:0] next_v;

    assign next_v = value_q - 16'h0001;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            value_q <= pwr_pkg::TMR_RESET;
            toggle_q <= 1'b0;
        end else if (ce) begin
            toggle_q <= 1'b0;
            if (load) begin
                value_q <= load_val;
            end else if (tick && count_en) begin
                value_q <= next_v;
                toggle_q <= next_v[pwr_pkg::TOGGLE_BIT] ^ value_q[pwr_pkg::TOGGLE_BIT];
            end
        end
    end
endmodule : idle_timer_ctr

// ===== rtl/halt_idle_power_control.sv
// Purpose: HALT and IDLE sequencing, wakeup pending logic and CAN power steps
// Assumes: aclk is the oscillator clock; pins are synchronous to it
// Notes: Unmapped addresses answer SLVERR; writes use byte lane 0 only
//
// Decided for this implementation: the address map and the AXI4-Lite interface to the registers.
`timescale 1ns/10ps
module halt_idle_power_control #(
    parameter bit HALT_ENABLE = 1'b1
) (
    // Clock, reset, enable
    input wire logic aclk,
    input wire logic aresetn,
    input wire logic ce,
    // AXI4-Lite write
    input wire logic [7:0] awaddr,
    input wire logic awvalid,
    output logic awready,
    input wire logic [31:0] wdata,
    input wire logic [3:0] wstrb,
    input wire logic wvalid,
    output logic wready,
    output logic [1:0] bresp,
    output logic bvalid,
    input wire logic bready,
    // AXI4-Lite read
    input wire logic [7:0] araddr,
    input wire logic arvalid,
    output logic arready,
    output logic [31:0] rdata,
    output logic [1:0] rresp,
    output logic rvalid,
    input wire logic rready,
    // Oscillator and wake pins
    input wire logic osc_ok,
    input wire logic [7:0] port_l_pins,
    input wire logic [7:0] port_m_pins,
    // Power and interrupt outputs
    output logic osc_enable,
    output logic core_clk_enable,
    output logic idle_timer_irq,
    output pwr_pkg::can_ctrl_t can_ctrl
);
    pwr_pkg::pwr_state_t state_q, state_d;
    pwr_pkg::reg_sel_t wsel, rsel;
    logic [7:0] aw_addr_q;
    logic [7:0] w_data_q;
    logic w_strb_q, aw_have_q, w_have_q;
    logic wr_fire, wr_byte, portg_wr, halt_wr, idle_wr, halt_ok;
    logic [7:0] pin_l_q, pin_m_q, rise_l, rise_m;
    logic [7:0] pend_l_q, pend_m_q, lwken_q, m_wake_en_q;
    logic [1:0] can_bus_ctrl_q;
    logic t_pend_q, int_en_q;
    logic wake_l, wake_m, wake_any, idle_wake, halt_wake, can_off;
    logic tick, tmr_toggle, tmr_zero, tmr_load;
    logic [15:0] tmr_val, tmr_load_val;
    logic [31:0] rd_val;

    function automatic pwr_pkg::reg_sel_t reg_sel(input logic [7:0] a);
        if (a == pwr_pkg::ADDR_PORTG) reg_sel = pwr_pkg::R_PORTG;
        else if (a == pwr_pkg::ADDR_INT_CTRL) reg_sel = pwr_pkg::R_INT_CTRL;
        else if (a == pwr_pkg::ADDR_CAN_BUS) reg_sel = pwr_pkg::R_CAN_BUS;
        else if (a == pwr_pkg::ADDR_M_WAKE_EN) reg_sel = pwr_pkg::R_M_WAKE_EN;
        else if (a == pwr_pkg::ADDR_LWKEN) reg_sel = pwr_pkg::R_LWKEN;
        else if (a == pwr_pkg::ADDR_LWKPND) reg_sel = pwr_pkg::R_LWKPND;
        else if (a == pwr_pkg::ADDR_MWKPND) reg_sel = pwr_pkg::R_MWKPND;
        else if (a == pwr_pkg::ADDR_STATUS) reg_sel = pwr_pkg::R_STATUS;
        else if (a == pwr_pkg::ADDR_TIMER) reg_sel = pwr_pkg::R_TIMER;
        else reg_sel = pwr_pkg::R_NONE;
    endfunction : reg_sel

    // Bus write channel: address and data may arrive in either order
    assign wsel = reg_sel(aw_addr_q);
    assign wr_fire = aw_have_q && w_have_q && !bvalid;
    assign wr_byte = wr_fire && w_strb_q;

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            awready <= 1'b1;
            wready <= 1'b1;
            aw_have_q <= 1'b0;
            w_have_q <= 1'b0;
            aw_addr_q <= 8'h00;
            w_data_q <= 8'h00;
            w_strb_q <= 1'b0;
            bvalid <= 1'b0;
            bresp <= pwr_pkg::RESP_OKAY;
        end else if (ce) begin
            if (awvalid && awready) begin
                aw_addr_q <= awaddr;
                aw_have_q <= 1'b1;
                awready <= 1'b0;
            end
            if (wvalid && wready) begin
                w_data_q <= wdata[7:0];
                w_strb_q <= wstrb[0];
                w_have_q <= 1'b1;
                wready <= 1'b0;
            end
            if (wr_fire) begin
                aw_have_q <= 1'b0;
                w_have_q <= 1'b0;
                bvalid <= 1'b1;
                bresp <= (wsel == pwr_pkg::R_NONE) ? pwr_pkg::RESP_SLVERR : pwr_pkg::RESP_OKAY;
            end
            if (bvalid && bready) begin
                bvalid <= 1'b0;
                awready <= 1'b1;
                wready <= 1'b1;
            end
        end
    end

    // Bus read channel
    assign rsel = reg_sel(araddr);

    always_comb begin
        rd_val = 32'h0000_0000;
        case (rsel)
            pwr_pkg::R_PORTG: begin
                rd_val[pwr_pkg::HALT_BIT] = (state_q == pwr_pkg::ST_HALT) || (state_q == pwr_pkg::ST_STARTUP);
                rd_val[pwr_pkg::IDLE_BIT] = (state_q == pwr_pkg::ST_IDLE);
            end
            pwr_pkg::R_INT_CTRL: begin
                rd_val[pwr_pkg::TPEND_BIT] = t_pend_q;
                rd_val[pwr_pkg::TEN_BIT] = int_en_q;
            end
            pwr_pkg::R_CAN_BUS: rd_val[1:0] = can_bus_ctrl_q;
            pwr_pkg::R_M_WAKE_EN: rd_val[7:0] = m_wake_en_q;
            pwr_pkg::R_LWKEN: rd_val[7:0] = lwken_q;
            pwr_pkg::R_LWKPND: rd_val[7:0] = pend_l_q;
            pwr_pkg::R_MWKPND: rd_val[7:0] = pend_m_q;
            pwr_pkg::R_STATUS: rd_val[3:0] = {osc_enable, core_clk_enable, 2'(state_q)};
            pwr_pkg::R_TIMER: rd_val[15:0] = tmr_val;
            default: rd_val = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            arready <= 1'b1;
            rvalid <= 1'b0;
            rdata <= 32'h0000_0000;
            rresp <= pwr_pkg::RESP_OKAY;
        end else if (ce) begin
            if (arvalid && arready) begin
                arready <= 1'b0;
                rvalid <= 1'b1;
                rdata <= rd_val;
                rresp <= (rsel == pwr_pkg::R_NONE) ? pwr_pkg::RESP_SLVERR : pwr_pkg::RESP_OKAY;
            end else if (rvalid && rready) begin
                rvalid <= 1'b0;
                arready <= 1'b1;
            end
        end
    end

    // Control registers written by software
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            lwken_q <= 8'h00;
            m_wake_en_q <= 8'h00;
            can_bus_ctrl_q <= 2'h0;
            int_en_q <= 1'b0;
        end else if (ce && wr_byte) begin
            if (wsel == pwr_pkg::R_LWKEN) lwken_q <= w_data_q;
            if (wsel == pwr_pkg::R_M_WAKE_EN) m_wake_en_q <= w_data_q;
            if (wsel == pwr_pkg::R_CAN_BUS) can_bus_ctrl_q <= w_data_q[1:0];
            if (wsel == pwr_pkg::R_INT_CTRL) int_en_q <= w_data_q[pwr_pkg::TEN_BIT];
        end
    end

    // Wakeup edges; the CAN line on port M bit 7 only counts with its comparator on
    assign rise_l = port_l_pins & ~pin_l_q;
    assign rise_m = port_m_pins & ~pin_m_q & {m_wake_en_q[pwr_pkg::CAN_WAKE_BIT], 7'h7F};

    // Pending flags: a new edge wins over a clear written in the same cycle
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            pin_l_q <= 8'h00;
            pin_m_q <= 8'h00;
            pend_l_q <= 8'h00;
            pend_m_q <= 8'h00;
            t_pend_q <= 1'b0;
        end else if (ce) begin
            pin_l_q <= port_l_pins;
            pin_m_q <= port_m_pins;
            if (wr_byte && wsel == pwr_pkg::R_LWKPND) pend_l_q <= (pend_l_q & w_data_q) | rise_l;
            else pend_l_q <= pend_l_q | rise_l;
            if (wr_byte && wsel == pwr_pkg::R_MWKPND) pend_m_q <= (pend_m_q & w_data_q) | rise_m;
            else pend_m_q <= pend_m_q | rise_m;
            if (tmr_toggle) t_pend_q <= 1'b1;
            else if (wr_byte && wsel == pwr_pkg::R_INT_CTRL) t_pend_q <= w_data_q[pwr_pkg::TPEND_BIT];
        end
    end

    assign wake_l = |(pend_l_q & lwken_q);
    assign wake_m = |(pend_m_q & m_wake_en_q);
    assign wake_any = wake_l || wake_m;
    assign halt_wake = wake_any;
    assign idle_wake = wake_l || (pend_m_q[pwr_pkg::CAN_WAKE_BIT] && m_wake_en_q[pwr_pkg::CAN_WAKE_BIT]);

    // Mode requests from the port data register
    assign portg_wr = wr_byte && (wsel == pwr_pkg::R_PORTG);
    assign halt_wr = portg_wr && w_data_q[pwr_pkg::HALT_BIT];
    assign idle_wr = portg_wr && w_data_q[pwr_pkg::IDLE_BIT] && !w_data_q[pwr_pkg::HALT_BIT];
    assign halt_ok = HALT_ENABLE && !wake_any;

    always_comb begin
        state_d = state_q;
        case (state_q)
            pwr_pkg::ST_RUN: begin
                if (halt_wr && halt_ok) state_d = pwr_pkg::ST_HALT;
                else if (idle_wr) state_d = pwr_pkg::ST_IDLE;
            end
            pwr_pkg::ST_IDLE: begin
                // Clearing the idle bit on a timer toggle is the same as leaving IDLE
                if (idle_wake || tmr_toggle) state_d = pwr_pkg::ST_RUN;
            end
            pwr_pkg::ST_HALT: begin
                if (halt_wake) state_d = pwr_pkg::ST_STARTUP;
            end
            pwr_pkg::ST_STARTUP: begin
                if (tmr_zero) state_d = pwr_pkg::ST_RUN;
            end
            default: state_d = pwr_pkg::ST_RUN;
        endcase
    end

    // Mode state and the clock gates that follow it
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            state_q <= pwr_pkg::ST_RUN;
            osc_enable <= 1'b1;
            core_clk_enable <= 1'b1;
        end else if (ce) begin
            state_q <= state_d;
            osc_enable <= (state_d != pwr_pkg::ST_HALT);
            core_clk_enable <= (state_d == pwr_pkg::ST_RUN);
        end
    end

    // Timer loads 256 on the HALT wakeup and the free-run value once released
    assign tmr_load = (state_q != state_d) &&
                      (state_d == pwr_pkg::ST_STARTUP || state_q == pwr_pkg::ST_STARTUP);
    assign tmr_load_val = (state_d == pwr_pkg::ST_STARTUP) ? pwr_pkg::STARTUP_LOAD : pwr_pkg::TMR_RESET;
    assign tmr_zero = (tmr_val == 16'h0000);

    instr_clock_div u_div (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .run(osc_enable && osc_ok),
        .tick(tick)
    );

    idle_timer_ctr u_tmr (
        .aclk(aclk),
        .aresetn(aresetn),
        .ce(ce),
        .tick(tick),
        .count_en(state_q != pwr_pkg::ST_HALT),
        .load(tmr_load),
        .load_val(tmr_load_val),
        .value_q(tmr_val),
        .toggle_q(tmr_toggle)
    );

    // Interrupt request and CAN transceiver power steps
    assign can_off = !can_bus_ctrl_q[pwr_pkg::CAN_RX_EN_LO] && !can_bus_ctrl_q[pwr_pkg::CAN_RX_EN_HI] &&
                     !m_wake_en_q[pwr_pkg::CAN_WAKE_BIT];

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            idle_timer_irq <= 1'b0;
            can_ctrl <= '0;
        end else if (ce) begin
            idle_timer_irq <= t_pend_q && int_en_q;
            can_ctrl.main_comp_en <= |can_bus_ctrl_q;
            can_ctrl.wake_comp_en <= m_wake_en_q[pwr_pkg::CAN_WAKE_BIT];
            can_ctrl.vref_en <= !can_off;
            can_ctrl.vref_oe_n <= can_off;
        end
    end

    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_halt_go;
        ce && state_q == pwr_pkg::ST_RUN && halt_wr && halt_ok;
    endsequence
    sequence s_halt_wake;
        ce && state_q == pwr_pkg::ST_HALT && halt_wake;
    endsequence
    sequence s_startup_done;
        ce && state_q == pwr_pkg::ST_STARTUP && tmr_zero;
    endsequence

    property p_halt_entry;
        s_halt_go |=> state_q == pwr_pkg::ST_HALT && !osc_enable && !core_clk_enable;
    endproperty
    a_halt_entry: assert property (p_halt_entry) else $error("halt not entered");
    property p_halt_refused;
        ce && halt_wr && (wake_any || !HALT_ENABLE) |=> state_q != pwr_pkg::ST_HALT;
    endproperty
    a_halt_refused: assert property (p_halt_refused) else $error("halt entered while refused");
    property p_idle_entry;
        ce && state_q == pwr_pkg::ST_RUN && idle_wr && !(halt_wr && halt_ok)
            |=> state_q == pwr_pkg::ST_IDLE && osc_enable && !core_clk_enable;
    endproperty
    a_idle_entry: assert property (p_idle_entry) else $error("idle not entered");
    property p_both_halt;
        ce && portg_wr && w_data_q[pwr_pkg::HALT_BIT] && w_data_q[pwr_pkg::IDLE_BIT] |=> state_q != pwr_pkg::ST_IDLE;
    endproperty
    a_both_halt: assert property (p_both_halt) else $error("idle taken with halt");
    property p_wake_start;
        s_halt_wake ##1 ce |=> state_q == pwr_pkg::ST_STARTUP && tmr_val <= pwr_pkg::STARTUP_LOAD && !core_clk_enable;
    endproperty
    a_wake_start: assert property (p_wake_start) else $error("startup not begun");
    property p_startup_end;
        s_startup_done |=> state_q == pwr_pkg::ST_RUN && core_clk_enable;
    endproperty
    a_startup_end: assert property (p_startup_end) else $error("clocks not released");
    property p_idle_timer_exit;
        ce && state_q == pwr_pkg::ST_IDLE && tmr_toggle |=> state_q == pwr_pkg::ST_RUN && t_pend_q;
    endproperty
    a_idle_timer_exit: assert property (p_idle_timer_exit) else $error("timer did not end idle");
    property p_idle_wake;
        ce && state_q == pwr_pkg::ST_IDLE && idle_wake |=> state_q == pwr_pkg::ST_RUN;
    endproperty
    a_idle_wake: assert property (p_idle_wake) else $error("wakeup did not end idle");
    property p_irq_gate;
        ce && !int_en_q |=> !idle_timer_irq;
    endproperty
    a_irq_gate: assert property (p_irq_gate) else $error("irq while disabled");
    property p_vref_off;
        (ce && can_off) [*2] |-> can_ctrl.vref_oe_n && !can_ctrl.vref_en && !can_ctrl.main_comp_en;
    endproperty
    a_vref_off: assert property (p_vref_off) else $error("reference still on");
    property p_halt_frozen;
        ce && state_q == pwr_pkg::ST_HALT ##1 ce && state_q == pwr_pkg::ST_HALT |-> $stable(tmr_val) && !tick;
    endproperty
    a_halt_frozen: assert property (p_halt_frozen) else $error("timer moved in halt");
endmodule : halt_idle_power_control

// ===== tb/osc_model.sv
// Purpose: Crystal oscillator seen from the sequencer
// Assumes: osc_enable is registered on aclk
// Notes: Amplitude becomes good only SETTLE cycles after enable
`timescale 1ns/10ps
module osc_model #(
    parameter int SETTLE = 300
) (
    // Clock
    input wire logic aclk,
    // Oscillator
    input wire logic osc_enable,
    output logic osc_ok
);
    int cnt = 0;
    initial osc_ok = 1'b0;
    // Stopped oscillator loses amplitude at once, restart is slow
    always @(posedge aclk) begin
        if (osc_enable !== 1'b1) begin
            cnt <= 0;
            osc_ok <= 1'b0;
        end else if (cnt < SETTLE) begin
            cnt <= cnt + 1;
        end else begin
            osc_ok <= 1'b1;
        end
    end
endmodule : osc_model

// ===== tb/test_halt_idle_power_control.sv
// Purpose: Register level test of the halt/idle sequencer
// Assumes: AXI4-Lite master tasks, one access at a time
// Notes: dut2 is built with HALT disabled and shares all inputs
`timescale 1ns/10ps
module test_halt_idle_power_control;
    logic aclk = 1'b0;
    logic aresetn = 1'b0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, port_l_pins = 8'h00;
    logic [7:0] port_m_pins = 8'h00;
    logic [3:0] wstrb = 4'h1;
    logic ce = 1'b1;
    logic [31:0] wdata = 32'h0, rdata, rv, tv;
    logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
    logic awready, wready, bvalid, arready, rvalid, osc_ok, osc_enable, core_en, irq, core2;
    logic [1:0] bresp, rresp, rr;
    pwr_pkg::can_ctrl_t can;
    int fail_count = 0;
    int n_checks = 0;
    int t;
    logic [7:0] ca[5] = '{pwr_pkg::ADDR_CAN_BUS, pwr_pkg::ADDR_CAN_BUS, pwr_pkg::ADDR_M_WAKE_EN,
                          pwr_pkg::ADDR_CAN_BUS, pwr_pkg::ADDR_M_WAKE_EN};
    logic [7:0] cd[5] = '{8'h01, 8'h02, 8'h80, 8'h00, 8'h00};
    logic [3:0] cx[5] = '{4'hA, 4'hA, 4'hE, 4'h6, 4'h1};

    always #4 aclk = ~aclk;

    halt_idle_power_control dut (.aclk(aclk), .aresetn(aresetn), .ce(ce), .awaddr(awaddr),
        .awvalid(awvalid), .awready(awready), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(wready), .bresp(bresp), .bvalid(bvalid), .bready(bready), .araddr(araddr),
        .arvalid(arvalid), .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid),
        .rready(rready), .osc_ok(osc_ok), .port_l_pins(port_l_pins), .port_m_pins(port_m_pins),
        .osc_enable(osc_enable), .core_clk_enable(core_en), .idle_timer_irq(irq), .can_ctrl(can));
    halt_idle_power_control #(.HALT_ENABLE(1'b0)) dut2 (.aclk(aclk), .aresetn(aresetn), .ce(ce),
        .awaddr(awaddr), .awvalid(awvalid), .awready(), .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid),
        .wready(), .bresp(), .bvalid(), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(), .rdata(), .rresp(), .rvalid(), .rready(rready), .osc_ok(osc_ok),
        .port_l_pins(port_l_pins), .port_m_pins(port_m_pins), .osc_enable(), .core_clk_enable(core2),
        .idle_timer_irq(), .can_ctrl());
    osc_model osc (.aclk(aclk), .osc_enable(osc_enable), .osc_ok(osc_ok));

    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        n_checks++;
        if (g !== e) begin
            fail_count++;
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
        end
    endtask : chk

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge aclk);
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        do begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
        end while (bvalid !== 1'b1);
        bready <= 1'b0;
    endtask : wr

    task automatic rd(input logic [7:0] a);
        @(posedge aclk);
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        do begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
        end while (rvalid !== 1'b1);
        rv = rdata;
        rr = rresp;
        rready <= 1'b0;
    endtask : rd

    task automatic rchk(input logic [7:0] a, input logic [31:0] e, input string nm);
        rd(a);
        chk(nm, e, rv);
    endtask : rchk

    task automatic pulse_pins(input logic [7:0] l, input logic [7:0] m);
        @(posedge aclk);
        port_l_pins <= l;
        port_m_pins <= m;
        repeat (3) @(posedge aclk);
        port_l_pins <= 8'h00;
        port_m_pins <= 8'h00;
    endtask : pulse_pins

    task automatic wait_core(input int lim);
        t = 0;
        while (core_en !== 1'b1 && t < lim) begin
            @(posedge aclk);
            t++;
        end
    endtask : wait_core

    task automatic give_verdict;
        if (fail_count == 0 && n_checks > 0) $display("Regression OK");
        else $display("Regression broken");
        $finish;
    endtask : give_verdict

    initial begin
        repeat (100000) @(posedge aclk);
        fail_count++;
        give_verdict();
    end

    initial begin
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rchk(pwr_pkg::ADDR_STATUS, 32'h0C, "status_reset");
        chk("can_reset", 32'h1, 32'(can));
        rd(8'h24);
        chk("rresp_unmapped", 32'(pwr_pkg::RESP_SLVERR), 32'(rr));
        for (int i = 0; i < 5; i++) begin
            wr(ca[i], 32'(cd[i]));
            @(posedge aclk);
            chk("can_ctrl", 32'(cx[i]), 32'(can));
        end
        wr(pwr_pkg::ADDR_M_WAKE_EN, 32'h80);
        wr(pwr_pkg::ADDR_PORTG, 32'h40);
        rchk(pwr_pkg::ADDR_STATUS, 32'h09, "status_idle");
        pulse_pins(8'h00, 8'h80);
        repeat (4) @(posedge aclk);
        rchk(pwr_pkg::ADDR_STATUS, 32'h0C, "status_canwake");
        wr(pwr_pkg::ADDR_MWKPND, 32'h00);
        wr(pwr_pkg::ADDR_M_WAKE_EN, 32'h00);
        wr(pwr_pkg::ADDR_PORTG, 32'h40);
        repeat (2) @(posedge aclk);
        pulse_pins(8'h00, 8'h80);
        repeat (4) @(posedge aclk);
        rchk(pwr_pkg::ADDR_STATUS, 32'h09, "status_canmask");
        wr(pwr_pkg::ADDR_LWKEN, 32'h01);
        wstrb <= 4'h0;
        wr(pwr_pkg::ADDR_LWKEN, 32'hFE);
        wstrb <= 4'h1;
        rchk(pwr_pkg::ADDR_LWKEN, 32'h01, "strobe_off");
        pulse_pins(8'h01, 8'h00);
        repeat (4) @(posedge aclk);
        rchk(pwr_pkg::ADDR_STATUS, 32'h0C, "status_lwake");
        rchk(pwr_pkg::ADDR_LWKPND, 32'h01, "lpend");
        wr(pwr_pkg::ADDR_PORTG, 32'h80);
        rchk(pwr_pkg::ADDR_STATUS, 32'h0C, "status_refused");
        wr(pwr_pkg::ADDR_LWKPND, 32'h00);
        wr(pwr_pkg::ADDR_PORTG, 32'hC0);
        rchk(pwr_pkg::ADDR_STATUS, 32'h02, "status_halt");
        rchk(pwr_pkg::ADDR_PORTG, 32'h80, "portg_halt");
        chk("nohalt_core", 32'h1, 32'(core2));
        rd(pwr_pkg::ADDR_TIMER);
        tv = rv;
        repeat (50) @(posedge aclk);
        rchk(pwr_pkg::ADDR_TIMER, tv, "timer_hold");
        pulse_pins(8'h01, 8'h00);
        repeat (2) @(posedge aclk);
        rchk(pwr_pkg::ADDR_STATUS, 32'h0B, "status_startup");
        wait_core(5000);
        chk("startup_cycles", 32'h1, 32'(t inside {[2820:2920]}));
        wr(pwr_pkg::ADDR_LWKPND, 32'h00);
        wr(pwr_pkg::ADDR_INT_CTRL, 32'h10);
        wr(pwr_pkg::ADDR_PORTG, 32'h40);
        repeat (2) @(posedge aclk);
        wait_core(45000);
        repeat (2) @(posedge aclk);
        chk("irq_set", 32'h1, 32'(irq));
        rchk(pwr_pkg::ADDR_INT_CTRL, 32'h30, "interrupt_control_reg_pend");
        rchk(pwr_pkg::ADDR_PORTG, 32'h00, "portg_idle_end");
        wr(pwr_pkg::ADDR_INT_CTRL, 32'h20);
        repeat (2) @(posedge aclk);
        chk("irq_masked", 32'h0, 32'(irq));
        rchk(pwr_pkg::ADDR_INT_CTRL, 32'h20, "pend_kept");
        wr(pwr_pkg::ADDR_INT_CTRL, 32'h00);
        rchk(pwr_pkg::ADDR_INT_CTRL, 32'h00, "pend_clear");
        rd(pwr_pkg::ADDR_TIMER);
        tv = rv;
        @(posedge aclk);
        ce <= 1'b0;
        repeat (100) @(posedge aclk);
        ce <= 1'b1;
        rd(pwr_pkg::ADDR_TIMER);
        chk("ce_freeze", 32'h1, 32'((tv - rv) < 32'h2));
        wr(pwr_pkg::ADDR_PORTG, 32'h80);
        aresetn <= 1'b0;
        repeat (3) @(posedge aclk);
        aresetn <= 1'b1;
        rchk(pwr_pkg::ADDR_STATUS, 32'h0C, "status_reset_exit");
        give_verdict();
    end
endmodule : test_halt_idle_power_control
